// ---- scp_params.svh ----
// Offsets, field positions and reset values of the status and command port
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
// Overview of operation
// [RULE1] Command unit state in bits 7:6: idle, suspended, low, high queue
// [RULE2] Receive unit state shows in bits 5:2; reserved codes never appear
// [RULE3] Software must ignore status bits 1:0; they read zero
// [RULE4] Unit state fields may lag behind accepted commands
// [RULE5] Software should track issued commands itself, not only status
// [RULE6] Command word writes as two bytes: interrupt control and command
// [RULE7] Command opcode at 23:20, receive opcode at 18:16, bit 19 zero
// [RULE8] A written nonzero opcode is offered to its unit at once
// [RULE9] Unit may take an offered command later, depending on DMA activity
// [RULE10] Command field clears to zero when its unit accepts it
// [RULE11] Per-event mask bits 31:26 keep their events off the interrupt
// [RULE12] Masks 31..26: done, frame, inactive, not ready, early, pause
// [RULE13] Writing one to bit 25 raises an interrupt; zero does nothing
// [RULE14] Bit 25 always reads zero
// [RULE15] Bit 25 and global mask written together raise no interrupt
// [RULE16] Global mask set keeps the interrupt pin deasserted
// [RULE17] Global mask overrides per-event masks and the software trigger
// [RULE18] Status byte 15:8 holds one flag per cause, bit 9 reserved
// [RULE19] Writing one to a pending flag clears it; other writes do nothing
// [RULE20] Events latch; interrupt is a level until every flag is cleared
// [RULE21] Software trigger sets flag bit 10, acknowledged like the others

`define SCP_ADDR_W      12
`define SCP_WORD_ADDR   12'h000
`define SCP_LANE_STAT   0
`define SCP_LANE_ACK    1
`define SCP_LANE_CMD    2
`define SCP_LANE_ICTL   3
`define SCP_SOFT_BIT    25
`define SCP_GMASK_BIT   24
`define SCP_IMASK_MSB   31
`define SCP_IMASK_LSB   26
`define SCP_COP_MSB     23
`define SCP_COP_LSB     20
`define SCP_ROP_MSB     18
`define SCP_ROP_LSB     16
`define SCP_FLAG_MSB    15
`define SCP_FLAG_LSB    8
`define SCP_FLAG_DONE   7
`define SCP_FLAG_FRAME  6
`define SCP_FLAG_SOFT   2
`define SCP_FLAG_EARLY  1
`define SCP_IMASK_RST   6'h00
`define SCP_GMASK_RST   1'h0

`endif

// ---- scp_pkg.sv ----
// Types shared by the status and command port modules
package scp_pkg;

  // Event pulses from the command and receive units
  typedef struct packed {
    logic cmd_done;
    logic frame_rx;
    logic cmd_inactive;
    logic rx_not_ready;
    logic mgmt_done;
    logic early_rx;
    logic flow_pause;
  } scp_events_t;

  // Command offered to the units
  typedef struct packed {
    logic [3:0] cmd_unit_opcode;
    logic       cmd_unit_valid;
    logic [2:0] rx_unit_opcode;
    logic       rx_unit_valid;
  } scp_cmd_t;

  typedef struct packed {
    logic [1:0]  cmd_state;
    logic [3:0]  rx_state;
    logic [5:0]  imask;
    logic        gmask;
    scp_cmd_t    cmd;
    logic [31:0] prdata;
    logic        int_n;
  } scp_port_state_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
  } scp_apb_state_t;

endpackage : scp_pkg

// ---- scp_event_latch.sv ----
// Sticky event flags, set wins over clear
`timescale 1ns/1ns
module scp_event_latch
  import scp_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  logic [W-1:0] next_flags;

  always_comb
  begin
    next_flags = (flags & ~clr) | set; // RULE19 RULE20
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= '0;
    else
      flags <= next_flags;
  end

endmodule : scp_event_latch

// ---- scp_apb_slave.sv ----
// APB handshake: one wait state, error on unmapped address
`timescale 1ns/1ns
module scp_apb_slave
  import scp_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic psel,
  input  wire logic penable,
  input  wire logic hit,
  output logic      pready,
  output logic      pslverr,
  output logic      load,
  output logic      commit
);

  scp_apb_state_t s;
  scp_apb_state_t next_s;

  // Read data is loaded on load; writes take effect on commit
  assign load   = psel & penable & ~s.pready;
  assign commit = psel & penable & s.pready;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;

  always_comb
  begin
    next_s.pready  = load;
    next_s.pslverr = load & ~hit;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

endmodule : scp_apb_slave

// ---- scp_port.sv ----
// Status and command word of the system control block, APB slave
`timescale 1ns/1ns
`include "scp_params.svh"
module scp_port
  import scp_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [`SCP_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [1:0]             cmd_unit_state,
  input  wire logic [3:0]             rx_unit_state,
  input  wire scp_events_t            events,
  input  wire logic                   cmd_unit_accept,
  input  wire logic                   rx_unit_accept,
  output scp_cmd_t                    cmd,
  output logic                        pci_int_n
);

  //////////////////////////////////////////////////////////////////////////
  // Bus handshake

  logic hit;
  logic load;
  logic commit;

  assign hit = (paddr == `SCP_WORD_ADDR);

  scp_apb_slave scp_apb_slave_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .hit     (hit),
    .pready  (pready),
    .pslverr (pslverr),
    .load    (load),
    .commit  (commit)
  );

  //////////////////////////////////////////////////////////////////////////
  // Write decode per byte lane

  logic wr;
  logic wr_ack;
  logic wr_cmd;
  logic wr_ictl;
  logic soft_set;

  assign wr      = commit & pwrite & hit;
  assign wr_ack  = wr & pstrb[`SCP_LANE_ACK];   // RULE19
  assign wr_cmd  = wr & pstrb[`SCP_LANE_CMD];   // RULE6
  assign wr_ictl = wr & pstrb[`SCP_LANE_ICTL];  // RULE6
  // Global mask written in the same access suppresses the trigger
  assign soft_set = wr_ictl & pwdata[`SCP_SOFT_BIT]
                    & ~pwdata[`SCP_GMASK_BIT];  // RULE13 RULE15 RULE21

  //////////////////////////////////////////////////////////////////////////
  // Event flags: status bits 15:8, with the reserved bit 9 slot
  // holding the early receive event, which has a mask but no flag

  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flags;
  logic [7:0] flag_en;

  assign flag_set = {events.cmd_done, events.frame_rx, events.cmd_inactive,
                     events.rx_not_ready, events.mgmt_done, soft_set,
                     events.early_rx, events.flow_pause};  // RULE18 RULE20

  // Early receive is hidden, so it is acknowledged with the frame flag
  assign flag_clr = wr_ack ? {pwdata[15:10], pwdata[14], pwdata[8]}
                           : 8'h00;                      // RULE19

  scp_event_latch #(
    .W (8)
  ) scp_event_latch_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (flag_set),
    .clr     (flag_clr),
    .flags   (flags)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register state

  scp_port_state_t s;
  scp_port_state_t next_s;

  function automatic logic rx_state_legal(input logic [3:0] code);
    rx_state_legal = (code == 4'h0) || (code == 4'h1) ||
                     (code == 4'h2) || (code == 4'h4);
  endfunction : rx_state_legal

  // Management and software events have no per-event mask
  assign flag_en = {~s.imask[5], ~s.imask[4], ~s.imask[3], ~s.imask[2],
                    1'b1, 1'b1, ~s.imask[1], ~s.imask[0]};  // RULE11 RULE12

  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = {s.imask, 1'b0, s.gmask,
               s.cmd.cmd_unit_opcode, 1'b0, s.cmd.rx_unit_opcode,
               flags[7:2], 1'b0, flags[0],
               s.cmd_state, s.rx_state, 2'b00};  // RULE1 RULE3 RULE7 RULE14
  end

  always_comb
  begin
    next_s = s;

    // Unit states are sampled once per cycle, so they trail the units
    next_s.cmd_state = cmd_unit_state;  // RULE1 RULE4
    if (rx_state_legal(rx_unit_state))
      next_s.rx_state = rx_unit_state;  // RULE2 RULE4

    // Unit takes the command whenever its DMA allows
    if (cmd_unit_accept && s.cmd.cmd_unit_valid)
    begin
      next_s.cmd.cmd_unit_opcode = 4'h0;  // RULE9 RULE10
      next_s.cmd.cmd_unit_valid  = 1'b0;
    end
    if (rx_unit_accept && s.cmd.rx_unit_valid)
    begin
      next_s.cmd.rx_unit_opcode = 3'h0;  // RULE9 RULE10
      next_s.cmd.rx_unit_valid  = 1'b0;
    end

    // A new write wins over an acceptance of the previous command
    if (wr_cmd)
    begin
      next_s.cmd.cmd_unit_opcode = pwdata[`SCP_COP_MSB:`SCP_COP_LSB];  // RULE7
      next_s.cmd.rx_unit_opcode  = pwdata[`SCP_ROP_MSB:`SCP_ROP_LSB];  // RULE7
      next_s.cmd.cmd_unit_valid  =
        |pwdata[`SCP_COP_MSB:`SCP_COP_LSB];  // RULE8
      next_s.cmd.rx_unit_valid   =
        |pwdata[`SCP_ROP_MSB:`SCP_ROP_LSB];  // RULE8
    end

    if (wr_ictl)
    begin
      next_s.imask = pwdata[`SCP_IMASK_MSB:`SCP_IMASK_LSB];  // RULE11
      next_s.gmask = pwdata[`SCP_GMASK_BIT];                 // RULE16
    end

    if (load)
      next_s.prdata = (!pwrite && hit) ? rd_word : 32'h0000_0000;

    // Global mask checked last so it overrides every other source
    next_s.int_n = ~(~s.gmask & |(flags & flag_en));  // RULE16 RULE17 RULE20
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s          <= '0;
      s.imask    <= `SCP_IMASK_RST;
      s.gmask    <= `SCP_GMASK_RST;
      s.int_n    <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign prdata    = s.prdata;
  assign cmd       = s.cmd;
  assign pci_int_n = s.int_n;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_cmd_state_read: assert property ( // RULE1
    load && !pwrite && hit |=> prdata[7:6] == $past(s.cmd_state))
  else $error("command unit state not reported in bits 7:6");

  chk_rx_state_legal: assert property ( // RULE2
    s.rx_state inside {4'h0, 4'h1, 4'h2, 4'h4})
  else $error("receive unit state holds a reserved code");

  chk_state_lag: assert property ( // RULE4
    rx_state_legal(rx_unit_state) |=> s.rx_state == $past(rx_unit_state))
  else $error("receive unit state not captured one cycle later");

  chk_fixed_zero_bits: assert property ( // RULE3
    prdata[1:0] == 2'b00 && prdata[19] == 1'b0 && prdata[9] == 1'b0)
  else $error("reserved status or command bit reads nonzero");

  chk_soft_reads_zero: assert property ( // RULE14
    prdata[`SCP_SOFT_BIT] == 1'b0)
  else $error("software trigger bit reads one");

  chk_cmd_offered: assert property ( // RULE8
    wr_cmd && pwdata[`SCP_COP_MSB:`SCP_COP_LSB] != 4'h0
    |=> cmd.cmd_unit_valid &&
        cmd.cmd_unit_opcode == $past(pwdata[`SCP_COP_MSB:`SCP_COP_LSB]))
  else $error("written command opcode not offered next cycle");

  chk_cmd_cleared: assert property ( // RULE10
    cmd_unit_accept && cmd.cmd_unit_valid && !wr_cmd
    |=> !cmd.cmd_unit_valid && cmd.cmd_unit_opcode == 4'h0)
  else $error("accepted command field not cleared");

  chk_soft_flag_set: assert property ( // RULE13
    soft_set |=> flags[`SCP_FLAG_SOFT] ##1 (s.gmask || !pci_int_n))
  else $error("software trigger did not raise the interrupt");

  chk_soft_with_mask: assert property ( // RULE15
    wr_ictl && pwdata[`SCP_SOFT_BIT] && pwdata[`SCP_GMASK_BIT]
    && !flags[`SCP_FLAG_SOFT]
    |=> !flags[`SCP_FLAG_SOFT] && s.gmask ##1 pci_int_n)
  else $error("trigger with global mask set raised an interrupt");

  chk_global_mask: assert property ( // RULE16
    s.gmask && $past(s.gmask) |-> pci_int_n)
  else $error("interrupt asserted while globally masked");

  chk_event_mask: assert property ( // RULE11
    !s.gmask && s.imask[5] && flags == 8'h80 |=> pci_int_n)
  else $error("masked command done event asserted the interrupt");

  chk_ack_clears: assert property ( // RULE19
    wr_ack && pwdata[`SCP_FLAG_MSB] && !events.cmd_done
    |=> !flags[`SCP_FLAG_DONE])
  else $error("acknowledged flag still pending");

  chk_int_level: assert property ( // RULE20
    !s.gmask && (flags & flag_en) != 8'h00 |=> !pci_int_n)
  else $error("pending unmasked event not driving the interrupt");

endmodule : scp_port

// ---- scp_port_tb.sv ----
// Self-checking testbench of the status and command port
`timescale 1ns/1ns
`include "scp_params.svh"
module scp_port_tb;
  import scp_pkg::*;
  logic                   pclk;
  logic                   presetn;
  logic [`SCP_ADDR_W-1:0] paddr;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [31:0]            pwdata;
  logic [3:0]             pstrb;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [1:0]             cmd_state_in;
  logic [3:0]             rx_state_in;
  scp_events_t            events;
  logic                   cacc;
  logic                   racc;
  scp_cmd_t               cmd;
  logic                   pci_int_n;
  logic [31:0]            rd;
  logic                   err;
  int                     failures;
  int                     check_count;

  scp_port scp_port_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_unit_state(cmd_state_in), .rx_unit_state(rx_state_in),
    .events(events), .cmd_unit_accept(cacc), .rx_unit_accept(racc),
    .cmd(cmd),
    .pci_int_n(pci_int_n));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////////
  task close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // Holds the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      failures++;
      close_out();
    end
  endtask : apb

  task rdw();
    apb(1'b0, `SCP_WORD_ADDR, 32'h0, 4'h0);
  endtask : rdw

  task wr(input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, `SCP_WORD_ADDR, d, s);
    repeat (2) @(negedge pclk);
  endtask : wr

  task pulse(input logic [6:0] v);
    @(posedge pclk);
    events <= v;
    @(posedge pclk);
    events <= 7'h00;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask : pulse

  //////////////////////////////////////////////////////////////////////////
  task t_state();
    logic [3:0] code [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
    for (int i = 0; i < 4; i++)
    begin
      cmd_state_in <= i[1:0];
      rx_state_in <= code[i];
      rdw();
      check("state", rd[7:0], {i[1:0], code[i], 2'b00});
    end
    // Reserved code must not show; last legal code stays
    rx_state_in <= 4'h3;
    rdw();
    check("rx_res", rd[5:2], 4'h4);
    $display("test state done");
  endtask : t_state

  task t_cmd();
    // Expected command comes from the bench's own record of what it issued
    wr(32'h001c0000, 4'b0100);
    check("cmd", cmd, 9'h039);
    rdw();
    check("cmd_rd", rd[23:16], 8'h14);
    wr(32'h00ff8000, 4'b0010);
    check("cmd_lane", cmd, 9'h039);
    @(posedge pclk);
    cacc <= 1'b1;
    @(posedge pclk);
    cacc <= 1'b0;
    repeat (2) @(negedge pclk);
    check("cmd_clr", cmd, 9'h009);
    @(posedge pclk);
    racc <= 1'b1;
    @(posedge pclk);
    racc <= 1'b0;
    repeat (2) @(negedge pclk);
    check("rx_clr", cmd, 9'h000);
    $display("test cmd done");
  endtask : t_cmd

  task t_event();
    logic [7:0] fb [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h01};
    logic [7:0] ak [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h40, 8'h01};
    for (int i = 0; i < 7; i++)
    begin
      pulse(7'h40 >> i);
      check("int_set", pci_int_n, 1'b0);
      rdw();
      check("flags", rd[15:8], fb[i]);
      wr({16'h0, ak[i], 8'h0}, 4'b0010);
      check("int_clr", pci_int_n, 1'b1);
    end
    pulse(7'h60);
    wr(32'h00008000, 4'b0010);
    rdw();
    check("part_ack", rd[15:8], 8'h40);
    check("int_hold", pci_int_n, 1'b0);
    wr(32'h00004000, 4'b0010);
    $display("test event done");
  endtask : t_event

  task t_mask();
    logic [6:0] ev [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h02, 7'h01};
    for (int i = 0; i < 6; i++)
    begin
      wr(32'h80000000 >> i, 4'b1000);
      pulse(ev[i]);
      check("masked", pci_int_n, 1'b1);
      pulse(ev[(i + 1) % 6]);
      check("unmasked", pci_int_n, 1'b0);
      wr(32'h0000ff00, 4'b0010);
    end
    wr(32'h0, 4'b1000);
    $display("test mask done");
  endtask : t_mask

  task t_soft();
    wr(32'h02000000, 4'b1000);
    check("soft_int", pci_int_n, 1'b0);
    rdw();
    check("soft_rd", rd[25], 1'b0);
    check("soft_flag", rd[15:8], 8'h04);
    wr(32'h00000400, 4'b0010);
    check("soft_ack", pci_int_n, 1'b1);
    wr(32'h0, 4'b1000);
    check("soft_zero", pci_int_n, 1'b1);
    $display("test soft done");
  endtask : t_soft

  task t_global();
    wr(32'h01000000, 4'b1000);
    pulse(7'h40);
    check("g_mask", pci_int_n, 1'b1);
    wr(32'h03000000, 4'b1000);
    rdw();
    check("g_soft", rd[15:8], 8'h80);
    check("g_rd", rd[24], 1'b1);
    wr(32'h0, 4'b1000);
    check("g_open", pci_int_n, 1'b0);
    wr(32'h00008000, 4'b0010);
    $display("test global done");
  endtask : t_global

  task t_unmap();
    apb(1'b1, 12'h004, 32'h01000000, 4'b1000);
    check("err_wr", err, 1'b1);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    check("err_rd", err, 1'b1);
    check("err_data", rd, 32'h0);
    rdw();
    check("ignored", rd[24], 1'b0);
    $display("test unmapped done");
  endtask : t_unmap

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    failures = 0;
    check_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, cacc, racc} = 5'h00;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    cmd_state_in = 2'h0;
    rx_state_in = 4'h0;
    events = 7'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdw();
    check("reset", rd, 32'h0);
    check("reset_int", pci_int_n, 1'b1);
    t_state();
    t_cmd();
    t_event();
    t_mask();
    t_soft();
    t_global();
    t_unmap();
    close_out();
  end
endmodule : scp_port_tb
